// [bench/tb.sv]
// Self-checking bench for the eight-bit universal shift register
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic clock_in, mode_select_lo, mode_select_hi, sync_clear_n;
  logic out_en_n_a, out_en_n_b, right_serial_in, left_serial_in;
  logic end_bit_low_out, end_bit_high_out;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0]  pio_in, pio_out, pio_oe_n;
  int errors, compares, cyc;
  initial begin pclk = 0; forever #25 pclk = ~pclk; end
  usr8_shift_register i_dut (.pclk, .presetn, .clk_en(1'b1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .clock_in, .mode_select_lo, .mode_select_hi, .sync_clear_n,
    .out_en_n_a, .out_en_n_b, .right_serial_in, .left_serial_in, .pio_in,
    .pio_out, .pio_oe_n, .end_bit_low_out, .end_bit_high_out);
  // Far side drives only while the register is set to load
  usr8_far_side i_far (.pio_out, .pio_oe_n, .ext_data(8'hA5),
    .ext_drive(mode_select_hi & mode_select_lo), .pio_in);
  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin errors++; $display("mismatch %s %h %h", n, e, g); end
  endtask : check
  task automatic finish_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // One bus transfer; answer taken at the rising edge that shows pready
  task automatic apb(logic w, logic [31:0] a);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, 32'h0};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (!pready && ++n < 20);
    if (n == 20) errors++;
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  // One pin clock event with mode m and controls c, then data compare
  // Controls settle a cycle first: pin release lags the selects by one pclk
  task automatic tick(logic [1:0] m, logic [4:0] c, logic [7:0] e);
    @(posedge pclk);
    {mode_select_hi, mode_select_lo} <= m;
    {sync_clear_n, out_en_n_b, out_en_n_a} <= c[4:2];
    {right_serial_in, left_serial_in} <= c[1:0];
    @(posedge pclk);
    clock_in <= 1'b1;
    @(posedge pclk);
    clock_in <= 1'b0;
    @(negedge pclk);
    check("data", {24'h0, e}, {24'h0, pio_out});
  endtask : tick
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 2000) begin errors++; finish_test(); end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, clock_in} = '0;
    {mode_select_lo, mode_select_hi, out_en_n_a, out_en_n_b} = '0;
    {right_serial_in, left_serial_in, sync_clear_n} = 3'h1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("reset", 32'h0, {24'h0, pio_out});
    tick(2'h3, 5'h10, 8'hA5);
    check("oe", 32'hFF, {24'h0, pio_oe_n});
    tick(2'h1, 5'h12, 8'h4B);
    tick(2'h2, 5'h10, 8'h25);
    check("ends", 32'h1, {30'h0, end_bit_high_out, end_bit_low_out});
    check("oe", 32'h0, {24'h0, pio_oe_n});
    tick(2'h2, 5'h15, 8'h92);
    check("oe", 32'hFF, {24'h0, pio_oe_n});
    tick(2'h1, 5'h18, 8'h24);
    tick(2'h0, 5'h13, 8'h24);
    tick(2'h3, 5'h03, 8'h00);
    apb(1'b1, 32'h0);
    apb(1'b0, 32'h4);
    check("status", 32'h700, rd);
    apb(1'b0, 32'h8);
    check("fault", 32'h1, {31'h0, err});
    finish_test();
  end
endmodule : tb

// [bench/usr8_far_side.sv]
// Far-side logic sharing the parallel pins with the register
module usr8_far_side (
  input  wire logic [7:0] pio_out,
  input  wire logic [7:0] pio_oe_n,
  input  wire logic       ext_drive,
  input  wire logic [7:0] ext_data,
  output logic      [7:0] pio_in
);
  // far side drives load data
  // Undriven pins float, so show the inverse rather than a stale level
  assign pio_in = (~pio_oe_n & pio_out)
                | (pio_oe_n & (ext_drive ? ext_data : ~pio_out));
endmodule : usr8_far_side

// [bench/usr8_sr_asserts.sv]
// Concurrent checks on the shift register pins and bus answer
module usr8_sr_asserts #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic             pclk, presetn, psel, penable, pready,
  input wire logic             clock_in, sync_clear_n, out_en_n_a,
  input wire logic             mode_select_lo, mode_select_hi, out_en_n_b,
  input wire logic             right_serial_in, left_serial_in,
  input wire logic             end_bit_low_out, end_bit_high_out,
  input wire logic [WIDTH-1:0] pio_in, pio_out, pio_oe_n
);
  // Pin clock seen one pclk earlier, to find its rising edge
  logic       ck_q;
  logic       ev;
  logic [1:0] sel;
  assign ev  = clock_in && !ck_q;
  assign sel = {mode_select_hi, mode_select_lo};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) ck_q <= 1'b0;
    else ck_q <= clock_in;
  // ==========================================================
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  load_take_a: assert property (ev && sync_clear_n && sel == 2'h3
    |=> pio_out == $past(pio_in)) else $error("load mismatch");
  shift_right_a: assert property (ev && sync_clear_n && sel == 2'h1
    |=> pio_out == {$past(pio_out[WIDTH-2:0]), $past(right_serial_in)})
    else $error("right shift mismatch");
  shift_left_a: assert property (ev && sync_clear_n && sel == 2'h2
    |=> pio_out == {$past(left_serial_in), $past(pio_out[WIDTH-1:1])})
    else $error("left shift mismatch");
  sync_clear_a: assert property (ev && !sync_clear_n
    |=> pio_out == '0) else $error("clear mismatch");
  hold_state_a: assert property (!ev || sync_clear_n && sel == 2'h0
    |=> $stable(pio_out)) else $error("state moved without event");
  pin_drive_a: assert property (1'b1 |=> pio_oe_n ==
    {WIDTH{$past(out_en_n_a || out_en_n_b || sel == 2'h3)}})
    else $error("pin drive mismatch");
  end_bits_a: assert property (end_bit_low_out == pio_out[0] &&
    end_bit_high_out == pio_out[WIDTH-1]) else $error("end bit mismatch");
  apb_answer_a: assert property (psel && !penable
    |=> pready ##1 !pready) else $error("bus answer mismatch");
endmodule : usr8_sr_asserts

bind usr8_shift_register usr8_sr_asserts #(.WIDTH(WIDTH)) i_chk (
  .pclk, .presetn, .psel, .penable, .pready, .clock_in, .sync_clear_n,
  .out_en_n_a, .mode_select_lo, .mode_select_hi, .out_en_n_b,
  .right_serial_in, .left_serial_in, .end_bit_low_out, .end_bit_high_out,
  .pio_in, .pio_out, .pio_oe_n);

// [core/usr8_pkg.sv]
// Shared constants and types for the eight-bit universal shift register
package usr8_pkg;

  // ==========================================================
  // Register geometry
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned APB_AW     = 4;

  // ==========================================================
  // Register byte offsets
  localparam logic [APB_AW-1:0] OFF_CTRL   = 4'h0;
  localparam logic [APB_AW-1:0] OFF_STATUS = 4'h4;

  // ==========================================================
  // Control register fields
  localparam int unsigned CTRL_OVR   = 0; // Software owns the mode selects
  localparam int unsigned CTRL_SEL0  = 1; // Software mode select, low bit
  localparam int unsigned CTRL_SEL1  = 2; // Software mode select, high bit
  localparam int unsigned CTRL_STEP  = 3; // Write one: one clock event
  localparam logic [2:0]  CTRL_RESET = 3'h0;

  // ==========================================================
  // Status register fields
  localparam int unsigned STAT_DATA_LSB = 0;
  localparam int unsigned STAT_OE_BIT   = 8;
  localparam int unsigned STAT_MODE_LSB = 9;

  // ==========================================================
  // Reset values
  localparam logic [DATA_WIDTH-1:0] DATA_RESET = 8'h00;
  localparam logic [DATA_WIDTH-1:0] OE_N_OFF   = 8'hFF;
  localparam logic [31:0]           WORD_ZERO  = 32'h0000_0000;

  // ==========================================================
  // Operating modes
  typedef enum logic [1:0] {
    USR8_HOLD,
    USR8_SHIFT_RIGHT,
    USR8_SHIFT_LEFT,
    USR8_LOAD
  } usr8_mode_t;

  // Whole state of the block
  typedef struct packed {
    logic [DATA_WIDTH-1:0] data;
    logic [DATA_WIDTH-1:0] oe_n;
    logic                  clock_q;
    logic [2:0]            ctrl;
    logic                  step;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } usr8_state_t;

endpackage : usr8_pkg

// [core/usr8_shift_register.sv]
// Eight-bit universal shift register with tri-state pins and APB control
//
// What this block does
// - Eight flip-flops clear, shift left, shift right, load or hold synchronously.
// - Mode selects choose the operation taken at each clock edge.
// - Low synchronous clear overrides selects and clears on next rising edge.
// - All other data register changes happen only on clock_in rising edges or a CTRL_STEP write.
// - Either high output enable puts all parallel pins in high impedance.
// - Register keeps operating while pin drivers are disabled.
// - Both selects high also release the pins for a parallel load.
// - Load mode takes pin data; far side drives it before the edge.
// - Bit 0 and bit 7 have dedicated always-driven outputs.
module usr8_shift_register #(
  parameter int unsigned WIDTH = usr8_pkg::DATA_WIDTH
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic [31:0]           prdata,
  // Device pins
  input  wire logic             clock_in,
  input  wire logic             mode_select_lo,
  input  wire logic             mode_select_hi,
  input  wire logic             sync_clear_n,
  input  wire logic             out_en_n_a,
  input  wire logic             out_en_n_b,
  input  wire logic             right_serial_in,
  input  wire logic             left_serial_in,
  input  wire logic [WIDTH-1:0] pio_in,
  output logic [WIDTH-1:0]      pio_out,
  output logic [WIDTH-1:0]      pio_oe_n,
  output logic                  end_bit_low_out,
  output logic                  end_bit_high_out
);

  // ==========================================================
  // Elaboration check
  if (WIDTH != usr8_pkg::DATA_WIDTH)
  begin : g_width_check
    $error("usr8_shift_register supports only an eight-bit register");
  end

  usr8_pkg::usr8_state_t state;
  usr8_pkg::usr8_state_t next_state;

  logic             sel_lo;
  logic             sel_hi;
  logic             clock_rise;
  logic             event_now;
  logic [WIDTH-1:0] shr_val;
  logic [WIDTH-1:0] shl_val;
  logic             apb_write;
  logic             apb_setup;
  logic             addr_ctrl;
  logic             addr_stat;
  usr8_pkg::usr8_mode_t mode;

  // ==========================================================
  // Mode decode, software may take the selects over
  assign sel_lo = state.ctrl[usr8_pkg::CTRL_OVR] ?
                  state.ctrl[usr8_pkg::CTRL_SEL0] : mode_select_lo;
  assign sel_hi = state.ctrl[usr8_pkg::CTRL_OVR] ?
                  state.ctrl[usr8_pkg::CTRL_SEL1] : mode_select_hi;

  always_comb
  begin
    case ({sel_hi, sel_lo})
      2'h0:    mode = usr8_pkg::USR8_HOLD;
      2'h1:    mode = usr8_pkg::USR8_SHIFT_RIGHT;
      2'h2:    mode = usr8_pkg::USR8_SHIFT_LEFT;
      default: mode = usr8_pkg::USR8_LOAD;
    endcase
  end

  // rising edge only
  // Pin is synchronous to pclk, so a plain previous-value compare suffices
  assign clock_rise = clock_in & ~state.clock_q;
  assign event_now  = clock_rise | state.step;

  // ==========================================================
  // Per-bit shift neighbours
  // serial entry points
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    if (i == 0)
    begin : g_lo
      assign shr_val[i] = right_serial_in;
      assign shl_val[i] = state.data[i+1];
    end
    else if (i == WIDTH-1)
    begin : g_hi
      assign shr_val[i] = state.data[i-1];
      assign shl_val[i] = left_serial_in;
    end
    else
    begin : g_mid
      assign shr_val[i] = state.data[i-1];
      assign shl_val[i] = state.data[i+1];
    end
  end

  // ==========================================================
  // APB decode
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & state.pready & pwrite;
  assign addr_ctrl = paddr[usr8_pkg::APB_AW-1:0] == usr8_pkg::OFF_CTRL &&
                     paddr[31:usr8_pkg::APB_AW] == '0;
  assign addr_stat = paddr[usr8_pkg::APB_AW-1:0] == usr8_pkg::OFF_STATUS &&
                     paddr[31:usr8_pkg::APB_AW] == '0;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    next_state         = state;
    next_state.clock_q = clock_in;
    next_state.step    = 1'b0;

    if (event_now)
    begin
      if (!sync_clear_n)
      begin
        next_state.data = usr8_pkg::DATA_RESET;
      end
      else
      begin
        case (mode)
          usr8_pkg::USR8_HOLD:        next_state.data = state.data;
          usr8_pkg::USR8_SHIFT_RIGHT: next_state.data = shr_val;
          usr8_pkg::USR8_SHIFT_LEFT:  next_state.data = shl_val;
          usr8_pkg::USR8_LOAD:        next_state.data = pio_in;
          default:                    next_state.data = state.data;
        endcase
      end
    end

    // drive only, state untouched
    // One pclk of latency keeps the enables glitch free
    if (out_en_n_a || out_en_n_b || mode == usr8_pkg::USR8_LOAD)
      next_state.oe_n = usr8_pkg::OE_N_OFF;
    else
      next_state.oe_n = '0;

    // APB answer: ready one cycle after setup
    if (apb_setup)
    begin
      next_state.pready  = 1'b1;
      next_state.pslverr = ~(addr_ctrl | addr_stat);
      next_state.prdata  = usr8_pkg::WORD_ZERO;
      if (!pwrite && addr_ctrl)
        next_state.prdata[2:0] = state.ctrl;
      if (!pwrite && addr_stat)
      begin
        next_state.prdata[usr8_pkg::STAT_DATA_LSB +: WIDTH] = state.data;
        next_state.prdata[usr8_pkg::STAT_OE_BIT] = state.oe_n[0];
        next_state.prdata[usr8_pkg::STAT_MODE_LSB +: 2] = {sel_hi, sel_lo};
      end
    end
    else
    begin
      next_state.pready  = 1'b0;
      next_state.pslverr = 1'b0;
    end

    // Control write; the step bit self-clears
    if (apb_write && addr_ctrl)
    begin
      next_state.ctrl = pwdata[2:0];
      next_state.step = pwdata[usr8_pkg::CTRL_STEP];
    end
  end

  // ==========================================================
  // State register, frozen while clk_en is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state.data    <= usr8_pkg::DATA_RESET;
      state.oe_n    <= usr8_pkg::OE_N_OFF;
      state.clock_q <= 1'b0;
      state.ctrl    <= usr8_pkg::CTRL_RESET;
      state.step    <= 1'b0;
      state.pready  <= 1'b0;
      state.pslverr <= 1'b0;
      state.prdata  <= usr8_pkg::WORD_ZERO;
    end
    else if (clk_en)
    begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs straight from state
  assign pready   = state.pready;
  assign pslverr  = state.pslverr;
  assign prdata   = state.prdata;
  assign pio_out  = state.data;
  assign pio_oe_n = state.oe_n;
  assign end_bit_low_out  = state.data[0];
  assign end_bit_high_out = state.data[WIDTH-1];

endmodule : usr8_shift_register
